// ---- include/aux_pkg.sv ----
// Shared constants and types for the auxiliary converter command link
`default_nettype none
package aux_pkg;
    // Command opcode; value is arbitrary
    localparam logic [7:0] MEASURE_OPCODE  = 8'h14;
    localparam logic [7:0] CTS_READY       = 8'hff;
    localparam logic [7:0] CTS_BUSY        = 8'h00;
    localparam logic [7:0] RESERVED_BYTE   = 8'h00;
    // Input-select byte fields
    localparam int         SEL_TEMP_BIT    = 4;
    localparam int         SEL_SUPPLY_BIT  = 3;
    localparam int         SEL_PIN_BIT     = 2;
    localparam logic [7:0] SEL_LEGAL_MASK  = 8'h1f;
    // Setup byte fields and default
    localparam int         CFG_TIME_LSB    = 4;
    localparam logic [3:0] CFG_DEFAULT_NIB = 4'hc;
    localparam logic [7:0] CFG_ZERO        = 8'h00;
    // Attenuation codes
    localparam logic [3:0] ATT_0V8         = 4'h0;
    localparam logic [3:0] ATT_1V6         = 4'h4;
    localparam logic [3:0] ATT_2V4         = 4'h8;
    localparam logic [3:0] ATT_3V6         = 4'h9;
    localparam logic [3:0] ATT_3V2         = 4'hc;
    // Converter shape
    localparam int         ADC_BITS        = 11;
    localparam int         CONV_STEPS      = 12;
    localparam int         STEP_CNT_W      = 17;
    localparam int         REPLY_BYTES     = 9;
    // Input channels of the analog mux
    localparam logic [1:0] CH_PIN          = 2'h0;
    localparam logic [1:0] CH_SUPPLY       = 2'h1;
    localparam logic [1:0] CH_TEMP         = 2'h2;
    // Wake timer setup bits
    localparam int         WAKE_EN_BIT     = 0;
    localparam int         LOW_DET_EN_BIT  = 1;
    // Supply threshold: millivolts; SUPPLY_DIV is in result counts
    localparam int         THR_BASE_MV     = 1500;
    localparam int         THR_STEP_MV     = 50;
    localparam int         THR_MAX_MV      = 3050;
    localparam int         SUPPLY_FULL_MV  = 3000;
    localparam int         SUPPLY_DIV      = 1280;

    typedef enum logic [2:0] {
        AUX_IDLE = 3'b000,
        AUX_SEL  = 3'b001,
        AUX_CFG  = 3'b010,
        AUX_CONV = 3'b011,
        AUX_DONE = 3'b100
    } aux_dev_state_t;

    typedef enum logic [2:0] {
        AUXH_IDLE = 3'b000,
        AUXH_SEL  = 3'b001,
        AUXH_CFG  = 3'b010,
        AUXH_POLL = 3'b011,
        AUXH_WAIT = 3'b100,
        AUXH_READ = 3'b101,
        AUXH_RWT  = 3'b110
    } aux_host_state_t;
endpackage
`default_nettype wire

// ---- include/aux_link_if.sv ----
// Command, reply and configuration link between host and converter
`timescale 1ns/1ps
`default_nettype none
interface aux_link_if;
    logic       cmd_valid;
    logic [7:0] cmd_data;
    logic       rd_req;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic [7:0] wake_timer_setup;
    logic [4:0] supply_low_threshold;
    logic       notify_on_gpio;

    modport device (
        input  cmd_valid, cmd_data, rd_req, wake_timer_setup,
               supply_low_threshold, notify_on_gpio,
        output rsp_valid, rsp_data
    );
    modport host (
        output cmd_valid, cmd_data, rd_req, wake_timer_setup,
               supply_low_threshold, notify_on_gpio,
        input  rsp_valid, rsp_data
    );
endinterface
`default_nettype wire

// ---- hw/aux_adc_dev.sv ----
// Device end: command-driven SAR converter with supply-low detector
//
// Summary of operation
// - SAR converter yields 11-bit results
// - Host sends command then input-select byte
// - Temperature unselected: skipped, reads zero
// - Supply unselected: skipped, reads zero
// - Pin unselected: skipped, reads zero
// - Two-bit index picks pin zero to three
// - Upper setup nibble sets conversion time
// - Lower nibble attenuation; zero byte defaults 0xC
// - Reply: CTS, pin, supply, temp, two reserved
// - Firmware scales temperature by 568/2560 minus 297
// - Firmware computes supply as 3*result/1280
// - Firmware divides pin result by attenuation divisor
// - Detector runs only with wake timer enabled
// - Detector enabled by wake timer setup bit
// - Each expiry compares supply against threshold
// - Threshold steps 50 mV, 1.5 V to 3.05 V
// - Notification on irq_out_n or a pin
`timescale 1ns/1ps
`default_nettype none
module aux_adc_dev (
    input  wire logic   clk,
    input  wire logic   rst_n,
    aux_link_if.device  link,
    input  wire logic   wakeup_expired,
    input  wire logic   sar_cmp_async,
    output logic [10:0] sar_dac,
    output logic [1:0]  sar_channel,
    output logic [1:0]  pin_index,
    output logic [3:0]  pin_attenuation_code,
    output logic        sar_sample,
    output logic        irq_out_n,
    output logic        supply_low_pin
);
    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Threshold code to supply counts; result r means 3*r/1280 volts
    function automatic logic [10:0] thr_counts(input logic [4:0] code);
        int mv;
        mv = aux_pkg::THR_BASE_MV + aux_pkg::THR_STEP_MV * int'(code);
        if (mv > aux_pkg::THR_MAX_MV) begin
            mv = aux_pkg::THR_MAX_MV;
        end
        return 11'((mv * aux_pkg::SUPPLY_DIV) / aux_pkg::SUPPLY_FULL_MV);
    endfunction

    // Step length in clocks: 2^(exponent+1), twelve steps per conversion
    function automatic logic [16:0] step_len(input logic [3:0] exp_code);
        // Five-bit sum so exponent 0xf gives 2^16 rather than wrapping to one clock
        return 17'h1 << ({1'b0, exp_code} + 5'h01);
    endfunction

    // Next channel at or after start that is selected
    function automatic logic [1:0] next_ch(input logic [2:0] en, input logic [1:0] start);
        logic [1:0] r;
        r = 2'h3;
        for (int i = 2; i >= 0; i--) begin
            if (en[i] && (2'(i) >= start)) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Comparator synchroniser; the analog edge is asynchronous to clk

    logic cmp_meta_reg;
    logic cmp_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_meta_reg <= 1'b0;
            cmp_reg      <= 1'b0;
        end else begin
            cmp_meta_reg <= sar_cmp_async;
            cmp_reg      <= cmp_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command, conversion and reply state

    aux_pkg::aux_dev_state_t state_reg, state_next;
    logic [2:0]  en_reg, en_next;         // {temp, supply, pin}
    logic [1:0]  pidx_reg, pidx_next;
    logic [3:0]  texp_reg, texp_next;
    logic [3:0]  att_reg, att_next;
    logic [1:0]  ch_reg, ch_next;
    logic [3:0]  step_reg, step_next;
    logic [16:0] cnt_reg, cnt_next;
    logic [10:0] trial_reg, trial_next;
    logic [10:0] mask_reg, mask_next;
    logic [15:0] res_reg [3];
    logic [15:0] res_next [3];
    logic        lowchk_reg, lowchk_next;  // Conversion is a detector check
    logic        ret_done_reg, ret_done_next; // Detector preempted a finished reply
    logic        lowpend_reg, lowpend_next;
    logic        low_reg, low_next;
    logic [3:0]  rptr_reg, rptr_next;
    logic        rv_reg, rv_next;
    logic [7:0]  rd_reg, rd_next;
    logic        smp_reg, smp_next;
    logic        irqn_reg, irqn_next;
    logic        lpin_reg, lpin_next;
    logic        step_end;
    logic        det_on;
    logic [7:0]  b;

    assign step_end = (cnt_reg == 17'h1);
    assign det_on   = link.wake_timer_setup[aux_pkg::WAKE_EN_BIT] &&
                      link.wake_timer_setup[aux_pkg::LOW_DET_EN_BIT];

    // Next-state logic for command intake, SAR steps and reply bytes
    always_comb begin
        state_next   = state_reg;
        en_next      = en_reg;
        pidx_next    = pidx_reg;
        texp_next    = texp_reg;
        att_next     = att_reg;
        ch_next      = ch_reg;
        step_next    = step_reg;
        cnt_next     = cnt_reg;
        trial_next   = trial_reg;
        mask_next    = mask_reg;
        res_next     = res_reg;
        lowchk_next  = lowchk_reg;
        ret_done_next = ret_done_reg;
        lowpend_next = lowpend_reg;
        low_next     = low_reg;
        rptr_next    = rptr_reg;
        rv_next      = 1'b0;
        rd_next      = rd_reg;
        smp_next     = 1'b0;
        b            = link.cmd_data;

        // Expiry while busy is held, never lost
        if (wakeup_expired && det_on) begin
            lowpend_next = 1'b1;
        end

        case (state_reg)
            aux_pkg::AUX_IDLE, aux_pkg::AUX_DONE: begin
                if (link.cmd_valid && (b == aux_pkg::MEASURE_OPCODE)) begin
                    state_next = aux_pkg::AUX_SEL;
                    rptr_next  = 4'h0;
                end else if (lowpend_next && det_on) begin
                    // Detector check reuses the converter on the supply input
                    lowpend_next = 1'b0;
                    lowchk_next  = 1'b1;
                    ret_done_next = (state_reg == aux_pkg::AUX_DONE);
                    ch_next      = aux_pkg::CH_SUPPLY;
                    texp_next    = aux_pkg::CFG_DEFAULT_NIB;
                    step_next    = 4'h0;
                    cnt_next     = step_len(aux_pkg::CFG_DEFAULT_NIB);
                    smp_next     = 1'b1;
                    state_next   = aux_pkg::AUX_CONV;
                end
            end
            aux_pkg::AUX_SEL: begin
                if (link.cmd_valid) begin
                    en_next    = {b[aux_pkg::SEL_TEMP_BIT], b[aux_pkg::SEL_SUPPLY_BIT],
                                  b[aux_pkg::SEL_PIN_BIT]};
                    pidx_next  = b[1:0];
                    state_next = aux_pkg::AUX_CFG;
                end
            end
            aux_pkg::AUX_CFG: begin
                if (link.cmd_valid) begin
                    if (b == aux_pkg::CFG_ZERO) begin
                        texp_next = aux_pkg::CFG_DEFAULT_NIB;
                        att_next  = aux_pkg::CFG_DEFAULT_NIB;
                    end else begin
                        texp_next = b[aux_pkg::CFG_TIME_LSB +: 4];
                        att_next  = b[3:0];
                    end
                    // Unselected fields read zero
                    for (int i = 0; i < 3; i++) begin
                        res_next[i] = 16'h0000;
                    end
                    lowchk_next = 1'b0;
                    ch_next     = next_ch(en_reg, aux_pkg::CH_PIN);
                    step_next   = 4'h0;
                    cnt_next    = step_len(texp_next);
                    smp_next    = (en_reg != 3'b000); // No strobe when nothing is selected
                    state_next  = (en_reg == 3'b000) ? aux_pkg::AUX_DONE : aux_pkg::AUX_CONV;
                end
            end
            aux_pkg::AUX_CONV: begin
                cnt_next = cnt_reg - 17'h1;
                if (step_end) begin
                    cnt_next  = step_len(texp_reg);
                    step_next = step_reg + 4'h1;
                    if (step_reg == 4'h0) begin
                        mask_next  = 11'h400;
                        trial_next = 11'h400;
                    end else begin
                        // Keep the trial bit only when input is above the DAC
                        trial_next = (cmp_reg ? trial_reg : (trial_reg & ~mask_reg)) |
                                     (mask_reg >> 1);
                        mask_next  = mask_reg >> 1;
                    end
                    if (step_reg == 4'(aux_pkg::CONV_STEPS - 1)) begin
                        if (lowchk_reg) begin
                            low_next    = (trial_next < thr_counts(link.supply_low_threshold));
                            lowchk_next = 1'b0;
                            // A pending reply must survive the detector check
                            state_next  = ret_done_reg ? aux_pkg::AUX_DONE : aux_pkg::AUX_IDLE;
                        end else begin
                            res_next[ch_reg] = {5'h00, trial_next};
                            ch_next          = next_ch(en_reg, ch_reg + 2'h1);
                            step_next        = 4'h0;
                            if (next_ch(en_reg, ch_reg + 2'h1) == 2'h3) begin
                                state_next = aux_pkg::AUX_DONE;
                            end else begin
                                smp_next = 1'b1;
                            end
                        end
                    end
                end
            end
            default: state_next = aux_pkg::AUX_IDLE;
        endcase

        // Reply stream; only CTS is returned until the command is done
        if (link.rd_req) begin
            rv_next = 1'b1;
            if (state_reg != aux_pkg::AUX_DONE || rptr_reg == 4'h0) begin
                rd_next = (state_reg == aux_pkg::AUX_DONE) ? aux_pkg::CTS_READY
                                                           : aux_pkg::CTS_BUSY;
                if (state_reg == aux_pkg::AUX_DONE) begin
                    rptr_next = 4'h1;
                end
            end else begin
                case (rptr_reg)
                    4'h1: rd_next = res_reg[aux_pkg::CH_PIN][15:8];
                    4'h2: rd_next = res_reg[aux_pkg::CH_PIN][7:0];
                    4'h3: rd_next = res_reg[aux_pkg::CH_SUPPLY][15:8];
                    4'h4: rd_next = res_reg[aux_pkg::CH_SUPPLY][7:0];
                    4'h5: rd_next = res_reg[aux_pkg::CH_TEMP][15:8];
                    4'h6: rd_next = res_reg[aux_pkg::CH_TEMP][7:0];
                    default: rd_next = aux_pkg::RESERVED_BYTE;
                endcase
                rptr_next = (rptr_reg == 4'(aux_pkg::REPLY_BYTES - 1)) ? 4'h0
                                                                       : rptr_reg + 4'h1;
            end
        end

        // Detector off clears its notification
        if (!det_on) begin
            low_next     = 1'b0;
            lowpend_next = 1'b0;
        end
        irqn_next = ~(low_next & ~link.notify_on_gpio);
        lpin_next = low_next & link.notify_on_gpio;
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= aux_pkg::AUX_IDLE;
            en_reg      <= 3'b000;
            pidx_reg    <= 2'h0;
            texp_reg    <= aux_pkg::CFG_DEFAULT_NIB;
            att_reg     <= aux_pkg::CFG_DEFAULT_NIB;
            ch_reg      <= aux_pkg::CH_PIN;
            step_reg    <= 4'h0;
            cnt_reg     <= 17'h00001;
            trial_reg   <= 11'h000;
            mask_reg    <= 11'h000;
            for (int i = 0; i < 3; i++) begin
                res_reg[i] <= 16'h0000;
            end
            lowchk_reg  <= 1'b0;
            ret_done_reg <= 1'b0;
            lowpend_reg <= 1'b0;
            low_reg     <= 1'b0;
            rptr_reg    <= 4'h0;
            rv_reg      <= 1'b0;
            rd_reg      <= 8'h00;
            smp_reg     <= 1'b0;
            irqn_reg    <= 1'b1;
            lpin_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            en_reg      <= en_next;
            pidx_reg    <= pidx_next;
            texp_reg    <= texp_next;
            att_reg     <= att_next;
            ch_reg      <= ch_next;
            step_reg    <= step_next;
            cnt_reg     <= cnt_next;
            trial_reg   <= trial_next;
            mask_reg    <= mask_next;
            res_reg     <= res_next;
            lowchk_reg  <= lowchk_next;
            ret_done_reg <= ret_done_next;
            lowpend_reg <= lowpend_next;
            low_reg     <= low_next;
            rptr_reg    <= rptr_next;
            rv_reg      <= rv_next;
            rd_reg      <= rd_next;
            smp_reg     <= smp_next;
            irqn_reg    <= irqn_next;
            lpin_reg    <= lpin_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops

    assign link.rsp_valid       = rv_reg;
    assign link.rsp_data        = rd_reg;
    assign sar_dac              = trial_reg;
    assign sar_channel          = ch_reg;
    assign pin_index            = pidx_reg;
    assign pin_attenuation_code = att_reg;
    assign sar_sample           = smp_reg;
    assign irq_out_n            = irqn_reg;
    assign supply_low_pin       = lpin_reg;
endmodule // aux_adc_dev
`default_nettype wire

// ---- hw/aux_adc_host.sv ----
// Host end: issues a measurement and collects the reply stream
`timescale 1ns/1ps
`default_nettype none
module aux_adc_host (
    input  wire logic        clk,
    input  wire logic        rst_n,
    aux_link_if.host         link,
    input  wire logic        start,
    input  wire logic [7:0]  input_select,
    input  wire logic [7:0]  conv_setup,
    input  wire logic [7:0]  wake_setup_in,
    input  wire logic [4:0]  low_threshold_in,
    input  wire logic        notify_gpio_in,
    output logic             busy,
    output logic             done,
    output logic [15:0]      pin_result,
    output logic [15:0]      supply_result,
    output logic [15:0]      temp_result
);
    aux_pkg::aux_host_state_t state_reg, state_next;
    logic [7:0]  sel_reg, sel_next;
    logic [7:0]  cfg_reg, cfg_next;
    logic [3:0]  idx_reg, idx_next;
    logic [63:0] sh_reg, sh_next;
    logic        cv_reg, cv_next;
    logic [7:0]  cd_reg, cd_next;
    logic        rq_reg, rq_next;
    logic        done_reg, done_next;
    logic [7:0]  ws_reg;
    logic [4:0]  lt_reg;
    logic        ng_reg;

    // Sequencer: three command bytes, CTS poll, then eight reply bytes
    always_comb begin
        state_next = state_reg;
        sel_next   = sel_reg;
        cfg_next   = cfg_reg;
        idx_next   = idx_reg;
        sh_next    = sh_reg;
        cv_next    = 1'b0;
        cd_next    = cd_reg;
        rq_next    = 1'b0;
        done_next  = 1'b0;
        case (state_reg)
            aux_pkg::AUXH_IDLE: begin
                if (start) begin
                    sel_next   = input_select & aux_pkg::SEL_LEGAL_MASK;
                    cfg_next   = conv_setup;
                    cv_next    = 1'b1;
                    cd_next    = aux_pkg::MEASURE_OPCODE;
                    state_next = aux_pkg::AUXH_SEL;
                end
            end
            aux_pkg::AUXH_SEL: begin
                cv_next    = 1'b1;
                cd_next    = sel_reg;
                state_next = aux_pkg::AUXH_CFG;
            end
            aux_pkg::AUXH_CFG: begin
                cv_next    = 1'b1;
                cd_next    = cfg_reg;
                state_next = aux_pkg::AUXH_POLL;
            end
            aux_pkg::AUXH_POLL: begin
                rq_next    = 1'b1;
                state_next = aux_pkg::AUXH_WAIT;
            end
            aux_pkg::AUXH_WAIT: begin
                if (link.rsp_valid) begin
                    if (link.rsp_data == aux_pkg::CTS_READY) begin
                        idx_next   = 4'h0;
                        rq_next    = 1'b1;
                        state_next = aux_pkg::AUXH_RWT;
                    end else begin
                        state_next = aux_pkg::AUXH_POLL;
                    end
                end
            end
            aux_pkg::AUXH_READ: begin
                rq_next    = 1'b1;
                state_next = aux_pkg::AUXH_RWT;
            end
            aux_pkg::AUXH_RWT: begin
                if (link.rsp_valid) begin
                    sh_next  = {sh_reg[55:0], link.rsp_data};
                    idx_next = idx_reg + 4'h1;
                    if (idx_reg == 4'(aux_pkg::REPLY_BYTES - 2)) begin
                        done_next  = 1'b1;
                        state_next = aux_pkg::AUXH_IDLE;
                    end else begin
                        state_next = aux_pkg::AUXH_READ;
                    end
                end
            end
            default: state_next = aux_pkg::AUXH_IDLE;
        endcase
    end

    // Registers; configuration is simply registered onto the link
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= aux_pkg::AUXH_IDLE;
            sel_reg   <= 8'h00;
            cfg_reg   <= 8'h00;
            idx_reg   <= 4'h0;
            sh_reg    <= 64'h0;
            cv_reg    <= 1'b0;
            cd_reg    <= 8'h00;
            rq_reg    <= 1'b0;
            done_reg  <= 1'b0;
            ws_reg    <= 8'h00;
            lt_reg    <= 5'h00;
            ng_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            sel_reg   <= sel_next;
            cfg_reg   <= cfg_next;
            idx_reg   <= idx_next;
            sh_reg    <= sh_next;
            cv_reg    <= cv_next;
            cd_reg    <= cd_next;
            rq_reg    <= rq_next;
            done_reg  <= done_next;
            ws_reg    <= wake_setup_in;
            lt_reg    <= low_threshold_in;
            ng_reg    <= notify_gpio_in;
        end
    end

    // Raw counts go out; scaling to volts and degrees is left to firmware
    assign link.cmd_valid            = cv_reg;
    assign link.cmd_data             = cd_reg;
    assign link.rd_req               = rq_reg;
    assign link.wake_timer_setup     = ws_reg;
    assign link.supply_low_threshold = lt_reg;
    assign link.notify_on_gpio       = ng_reg;
    assign busy                      = (state_reg != aux_pkg::AUXH_IDLE);
    assign done                      = done_reg;
    assign pin_result                = sh_reg[63:48];
    assign supply_result             = sh_reg[47:32];
    assign temp_result               = sh_reg[31:16];
endmodule // aux_adc_host
`default_nettype wire

// ---- test/aux_adc_command_and_low_batt_detect_checker.sv ----
// Checker for the command and reply link between host and converter
`timescale 1ns/1ps
`default_nettype none
module aux_link_checker (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_data,
    input wire logic       rd_req,
    input wire logic       rsp_valid,
    input wire logic [7:0] rsp_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    // Opcode counts only at the head of a burst; select bytes may alias it
    sequence op_s;
        !$past(cmd_valid) && cmd_valid && cmd_data == aux_pkg::MEASURE_OPCODE;
    endsequence
    rsp_due_a: assert property (rd_req |=> rsp_valid)
        else $error("read request not answered");
    rsp_cause_a: assert property (rsp_valid |-> $past(rd_req))
        else $error("reply byte without request");
    rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
        else $error("reply strobe too long");
    rsp_hold_a: assert property (!rsp_valid |-> $stable(rsp_data))
        else $error("reply byte changed without strobe");
    sel_clean_a: assert property (op_s |=> cmd_valid && cmd_data[7:5] == 3'h0)
        else $error("select byte upper bits set");
    cmd_burst_a: assert property (op_s |=> cmd_valid ##1 cmd_valid ##1 (!cmd_valid && rd_req))
        else $error("command burst malformed");
    rd_pulse_a: assert property (rd_req |=> !rd_req)
        else $error("read request too long");
    cmd_rd_a: assert property (cmd_valid |-> !rd_req)
        else $error("read during command");
    cover property (op_s);
    cover property (rsp_valid && rsp_data == aux_pkg::CTS_BUSY);
    cover property (rsp_valid && rsp_data == aux_pkg::CTS_READY);
endmodule // aux_link_checker
`default_nettype wire

// ---- test/aux_adc_command_and_low_batt_detect_tb.sv ----
// Testbench joining host and converter ends over the command link
`timescale 1ns/1ps
`default_nettype none
module aux_adc_command_and_low_batt_detect_tb;
    logic clk = 0, rst_n = 0, start = 0, cmp = 0, busy, done, smp, irq_n, lowp;
    logic [7:0] sel = 0, cfg = 0;
    logic [15:0] pin_r, sup_r, tmp_r;
    logic [10:0] dac;
    logic [1:0] ch, pidx;
    logic [3:0] att;
    logic [3:0] codes [5] = '{4'h0, 4'h4, 4'h8, 4'h9, 4'hc};
    logic [47:0] expq [$];
    int n_mismatch = 0, num_checks = 0, seed = 32'h001068ea, i, r;
    aux_link_if link ();
    // Detector inputs tied: its conversion runs about 98k clocks
    aux_adc_dev i_aux_adc_dev (.clk(clk), .rst_n(rst_n), .link(link), .wakeup_expired(1'b0),
        .sar_cmp_async(cmp), .sar_dac(dac), .sar_channel(ch), .pin_index(pidx),
        .pin_attenuation_code(att), .sar_sample(smp), .irq_out_n(irq_n), .supply_low_pin(lowp));
    aux_adc_host i_aux_adc_host (.clk(clk), .rst_n(rst_n), .link(link), .start(start),
        .input_select(sel), .conv_setup(cfg), .wake_setup_in(8'h00), .low_threshold_in(5'h00),
        .notify_gpio_in(1'b0), .busy(busy), .done(done), .pin_result(pin_r),
        .supply_result(sup_r), .temp_result(tmp_r));
    aux_link_checker i_aux_link_checker (.clk(clk), .rst_n(rst_n), .cmd_valid(link.cmd_valid),
        .cmd_data(link.cmd_data), .rd_req(link.rd_req), .rsp_valid(link.rsp_valid),
        .rsp_data(link.rsp_data));
    initial forever #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task check(input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        check(48'(expq.size()), 48'h0);
        check({46'h0, irq_n, lowp}, 48'h2);
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Constant comparator level: SAR settles to all ones or all zeros
    task measure(input logic [7:0] s, input logic c, input logic [3:0] e, input logic [3:0] a);
        logic [15:0] v;
        logic [2:0] pend;
        int k, gap, ns, j;
        v = c ? 16'h07ff : 16'h0000;
        pend = s[4:2];
        gap = 0;
        ns = 0;
        @(negedge clk);
        sel = s;
        // Only an empty select gets a zero setup byte: its default is slow
        cfg = (s == 8'h00) ? 8'h00 : {e, a};
        cmp = c;
        start = 1;
        expq.push_back({s[2] ? v : 16'h0, s[3] ? v : 16'h0, s[4] ? v : 16'h0});
        @(negedge clk);
        start = 0;
        check({47'h0, busy}, 48'h1);
        for (k = 0; k < 1000 && done !== 1'b1; k++) begin
            @(negedge clk);
            gap++;
            if (smp === 1'b1) begin
                // Strobes walk the selected inputs: pin, supply, temperature
                j = pend[0] ? 0 : (pend[1] ? 1 : 2);
                check({46'h0, ch}, 48'(j));
                pend[j] = 1'b0;
                if (ns > 0) check(48'(gap), 48'(aux_pkg::CONV_STEPS << (e + 1)));
                ns++;
                gap = 0;
            end
        end
        if (k == 1000) begin
            n_mismatch++;
            end_of_test();
        end
        check(48'(ns), 48'($countones(s[4:2])));
        if (s[4:2] != 3'b000) check({37'h0, dac}, {37'h0, v[10:0]});
        check({42'h0, att, pidx},
              {42'h0, (s == 8'h00) ? aux_pkg::CFG_DEFAULT_NIB : a, s[1:0]});
        check({47'h0, busy}, 48'h0);
        @(negedge clk);
    endtask
    // Monitor pairs each done with the oldest expected reply; looks off the launching edge
    always @(negedge clk) begin
        if (done === 1'b1) begin
            if (expq.size() == 0) check(48'h1, 48'h0);
            else check({pin_r, sup_r, tmp_r}, expq.pop_front());
        end
    end
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1;
        measure(8'h00, 1'b1, 4'h0, 4'h0);
        for (i = 0; i < 5; i++) measure(8'h1c | i[1:0], i[0], {3'h0, i[1]} + 4'h1, codes[i]);
        for (i = 0; i < 8; i++) begin
            r = $random(seed);
            measure(r[7:0], r[8], {3'h0, r[12]} + 4'h1, codes[r[11:9] % 5]);
        end
        end_of_test();
    end
endmodule // aux_adc_command_and_low_batt_detect_tb
`default_nettype wire
